// ==== hdl/ccr_config_cycle_router.sv ====
// Configuration cycle router: pointer and data window on processor I/O, routing to
// internal registers, hub link or graphics port bus.
// Assumes hub link and graphics port logic run on sys_clk and hold done for one cycle.
module ccr_config_cycle_router
  import ccr_pkg::*;
(
  input wire logic sys_clk, // 100 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic io_req, // Processor I/O request, one-cycle pulse
  input wire ccr_io_req_s io_cmd, // Processor I/O request contents
  output logic io_busy, // Request in progress, new requests ignored
  output logic io_done, // Answer pulse
  output logic [31:0] io_rdata, // Read data, valid with io_done
  output logic hub_req, // Hub link request, held until hub_done
  output ccr_hub_kind_e hub_kind, // Hub link cycle kind
  output logic gp_req, // Graphics port request, held until gp_done
  output logic gp_type1, // Graphics port cycle is Type 1
  output ccr_link_s link_out, // Address, enables and data for hub or graphics cycle
  input wire logic hub_done, // Hub link completion pulse
  input wire logic [31:0] hub_rdata, // Hub link read data
  input wire logic gp_done, // Graphics port completion pulse
  input wire logic [31:0] gp_rdata, // Graphics port read data
  output logic [31:0] target_ptr // Current pointer contents
);

  typedef enum logic [1:0] {
    CCR_ST_IDLE = 2'b00,
    CCR_ST_HUB = 2'b01,
    CCR_ST_GP = 2'b10
  } ccr_state_e;

  typedef struct packed {
    ccr_state_e state;
    logic busy;
    logic [31:0] ptr;
    logic io_done;
    logic [31:0] io_rdata;
    logic hub_req;
    ccr_hub_kind_e hub_kind;
    logic gp_req;
    logic gp_type1;
    ccr_link_s link;
  } ccr_state_s;

  ccr_state_s r_reg, r_next;

  function automatic logic dword_hit(input logic [15:0] a, input logic [15:0] base);
    return a[15:2] == base[15:2];
  endfunction

  ccr_route_e route;
  logic [31:0] cfg_addr;
  logic [31:0] int_rdata;
  logic [7:0] sec_bus;
  logic [7:0] sub_bus;
  logic take;
  logic ptr_hit;
  logic data_hit;
  logic int_wr;

  ccr_route_decode u_decode (
    .ptr(r_reg.ptr),
    .sec_bus(sec_bus),
    .sub_bus(sub_bus),
    .route(route),
    .out_addr(cfg_addr)
  );

  ccr_int_regs u_int_regs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(int_wr),
    .ptr(r_reg.ptr),
    .be(io_cmd.be),
    .wdata(io_cmd.wdata),
    .rdata(int_rdata),
    .sec_bus(sec_bus),
    .sub_bus(sub_bus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode
  always_comb begin
    take = io_req && (r_reg.state == CCR_ST_IDLE);
    ptr_hit = dword_hit(io_cmd.addr, CCR_PTR_ADDR);
    data_hit = dword_hit(io_cmd.addr, CCR_DATA_ADDR);
    int_wr = take && data_hit && (route == CCR_RT_INT) && io_cmd.write;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.io_done = 1'b0;
    unique case (r_reg.state)
      CCR_ST_IDLE: begin
        if (take) begin
          r_next.link.write = io_cmd.write;
          r_next.link.be = io_cmd.be;
          r_next.link.wdata = io_cmd.wdata;
          if (ptr_hit && io_cmd.be == CCR_BE_DWORD) begin
            // Full dword: the pointer itself, answered next cycle
            if (io_cmd.write) begin
              r_next.ptr = io_cmd.wdata & CCR_PTR_WMASK;
            end else begin
              r_next.io_rdata = r_reg.ptr;
            end
            r_next.io_done = 1'b1;
          end else if (data_hit && route == CCR_RT_INT) begin
            if (!io_cmd.write) begin
              r_next.io_rdata = int_rdata;
            end
            r_next.io_done = 1'b1;
          end else if (data_hit && (route == CCR_RT_GP0 || route == CCR_RT_GP1)) begin
            r_next.state = CCR_ST_GP;
            r_next.busy = 1'b1;
            r_next.gp_req = 1'b1;
            r_next.gp_type1 = (route == CCR_RT_GP1);
            r_next.link.addr = cfg_addr;
          end else if (data_hit && (route == CCR_RT_HUB0 || route == CCR_RT_HUB1)) begin
            r_next.state = CCR_ST_HUB;
            r_next.busy = 1'b1;
            r_next.hub_req = 1'b1;
            r_next.hub_kind = (route == CCR_RT_HUB1) ? CCR_HK_CFG1 : CCR_HK_CFG0;
            r_next.link.addr = cfg_addr;
          end else begin
            // Partial pointer access, disabled window or foreign port: plain I/O
            r_next.state = CCR_ST_HUB;
            r_next.busy = 1'b1;
            r_next.hub_req = 1'b1;
            r_next.hub_kind = CCR_HK_IO;
            r_next.link.addr = {16'h0000, io_cmd.addr};
          end
        end
      end
      CCR_ST_HUB: begin
        if (hub_done) begin
          r_next.state = CCR_ST_IDLE;
          r_next.busy = 1'b0;
          r_next.hub_req = 1'b0;
          r_next.io_done = 1'b1;
          if (!r_reg.link.write) begin
            r_next.io_rdata = hub_rdata;
          end
        end
      end
      CCR_ST_GP: begin
        if (gp_done) begin
          r_next.state = CCR_ST_IDLE;
          r_next.busy = 1'b0;
          r_next.gp_req = 1'b0;
          r_next.io_done = 1'b1;
          if (!r_reg.link.write) begin
            r_next.io_rdata = gp_rdata;
          end
        end
      end
      default: begin
        r_next.state = CCR_ST_IDLE;
        r_next.busy = 1'b0;
        r_next.hub_req = 1'b0;
        r_next.gp_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '{state: CCR_ST_IDLE, ptr: CCR_PTR_RESET, hub_kind: CCR_HK_IO, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    io_busy = r_reg.busy;
    io_done = r_reg.io_done;
    io_rdata = r_reg.io_rdata;
    hub_req = r_reg.hub_req;
    hub_kind = r_reg.hub_kind;
    gp_req = r_reg.gp_req;
    gp_type1 = r_reg.gp_type1;
    link_out = r_reg.link;
    target_ptr = r_reg.ptr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ptr_dword_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && ptr_hit && io_cmd.be == CCR_BE_DWORD && io_cmd.write
    |=> target_ptr == ($past(io_cmd.wdata) & CCR_PTR_WMASK) && io_done)
    else $error("pointer dword write not stored");

  a_partial_ptr_io: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && ptr_hit && io_cmd.be != CCR_BE_DWORD
    |=> hub_req && hub_kind == CCR_HK_IO && $stable(target_ptr))
    else $error("partial pointer access not passed through");

  a_disabled_no_cfg: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && !target_ptr[CCR_EN_BIT]
    |=> !gp_req && hub_kind == CCR_HK_IO)
    else $error("config cycle with enable clear");

  a_window_config: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && target_ptr[CCR_EN_BIT] && route != CCR_RT_INT
    |=> (gp_req || (hub_req && hub_kind != CCR_HK_IO)) && link_out.addr == $past(cfg_addr))
    else $error("window access not translated");

  a_internal_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && route == CCR_RT_INT
    |=> io_done && !hub_req && !gp_req && !io_busy)
    else $error("internal access left the chip");

  a_int_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && route == CCR_RT_INT && !io_cmd.write
    |=> io_done && io_rdata == $past(int_rdata))
    else $error("internal read data not returned");

  a_primary_bus_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    route == CCR_RT_INT && r_reg.ptr[15:2] == {CCR_DEV_GFX_BRIDGE, 3'h0, CCR_BUSNUM_DW}
    |-> int_rdata[7:0] == 8'h00 && int_rdata[31:24] == 8'h00)
    else $error("graphics bridge primary bus not zero");

  a_hub_type1_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && route == CCR_RT_HUB1
    |=> hub_kind == CCR_HK_CFG1 && link_out.addr[1:0] == CCR_A10_TYPE1
        && link_out.addr[31:2] == $past(target_ptr[31:2]))
    else $error("hub type 1 packet address wrong");

  a_hub_type0_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && route == CCR_RT_HUB0
    |=> hub_req && link_out.addr == {$past(target_ptr[31:2]), CCR_A10_TYPE0})
    else $error("bus 0 forward address wrong");

  a_window_disabled_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && !target_ptr[CCR_EN_BIT]
    |=> hub_req && link_out.addr == {16'h0000, $past(io_cmd.addr)})
    else $error("disabled window access not plain I/O");

  a_bus0_forward: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && target_ptr[CCR_EN_BIT] && target_ptr[23:16] == 8'h00
    && !(target_ptr[15:11] inside {5'h00, 5'h01, 5'h03, 5'h06})
    |=> hub_req && hub_kind == CCR_HK_CFG0)
    else $error("bus 0 foreign device not forwarded");

  a_gp_type0_idsel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && route == CCR_RT_GP0
    |=> !gp_type1 && link_out.addr[31:16] == ($past(target_ptr[15]) ? 16'h0000
        : (16'h0001 << $past(target_ptr[14:11]))))
    else $error("type 0 device select wrong");

  a_gp_type1_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gp_req && gp_type1 |-> target_ptr[23:16] > sec_bus && target_ptr[23:16] <= sub_bus)
    else $error("graphics type 1 outside bridge range");

  a_gp_type1_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    take && data_hit && route == CCR_RT_GP1
    |=> gp_req && gp_type1 && link_out.addr == {8'h00, $past(target_ptr[23:2]), CCR_A10_TYPE1})
    else $error("graphics type 1 address wrong");

  a_gp_type0_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gp_req && !gp_type1 |-> target_ptr[23:16] == sec_bus && sec_bus != 8'h00)
    else $error("graphics type 0 bus mismatch");

  a_hub_complete: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hub_req && hub_done |=> io_done && !hub_req && !io_busy)
    else $error("hub completion not answered");

  a_gp_complete: assert property (@(posedge sys_clk) disable iff (!rst_n)
    gp_req && gp_done
    |=> io_done && !gp_req && !io_busy)
    else $error("graphics completion not answered");

  a_busy_refuse: assert property (@(posedge sys_clk) disable iff (!rst_n)
    io_req && io_busy
    |=> $stable(target_ptr) && $stable(link_out))
    else $error("request taken while busy");

  a_one_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(hub_req && gp_req) && io_busy == (hub_req || gp_req))
    else $error("busy does not match outstanding cycle");

  a_ptr_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (target_ptr & ~CCR_PTR_WMASK) == 32'h0000_0000)
    else $error("pointer reserved bits set");

endmodule

// ==== hdl/ccr_int_regs.sv ====
// Configuration registers of the internal bus 0 devices, one dword array per device.
// Assumes the caller has already decided that the access targets an internal device.
module ccr_int_regs
  import ccr_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic wr_en, // Write strobe, one cycle
  input wire logic [31:0] ptr, // Target pointer selecting device, function, dword
  input wire logic [3:0] be, // Byte enables
  input wire logic [31:0] wdata, // Write data
  output logic [31:0] rdata, // Read data for the selected dword
  output logic [7:0] sec_bus, // Graphics bridge secondary bus
  output logic [7:0] sub_bus // Graphics bridge subordinate bus
);

  typedef struct packed {
    logic [CCR_INT_DEVS*CCR_INT_DWORDS-1:0][31:0] words;
  } ccr_int_state_s;

  ccr_int_state_s r_reg, r_next;

  function automatic logic [1:0] slot(input logic [4:0] dev);
    unique case (dev)
      CCR_DEV_GFX_BRIDGE: return 2'd1;
      CCR_DEV_STREAM: return 2'd2;
      CCR_DEV_OVERFLOW: return 2'd3;
      default: return 2'd0;
    endcase
  endfunction

  logic [5:0] idx;
  logic hit;
  logic [31:0] mask;
  logic [31:0] merged;

  always_comb begin
    r_next = r_reg;
    idx = {slot(ptr[CCR_DEV_LSB +: 5]), ptr[CCR_REG_LSB +: 4]};
    // Only function 0, dwords below the array size exist; the rest read zero
    hit = (ptr[CCR_FUNC_LSB +: 3] == 3'd0) && (ptr[7:6] == 2'd0);
    mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merged = (r_reg.words[idx] & ~mask) | (wdata & mask);
    if (idx == {2'd1, CCR_BUSNUM_DW[3:0]}) begin
      merged = merged & CCR_BUSNUM_WMASK;
    end
    rdata = hit ? r_reg.words[idx] : 32'h0000_0000;
    if (wr_en && hit) begin
      r_next.words[idx] = merged;
    end
    sec_bus = r_reg.words[{2'd1, CCR_BUSNUM_DW[3:0]}][15:8];
    sub_bus = r_reg.words[{2'd1, CCR_BUSNUM_DW[3:0]}][23:16];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// ==== hdl/ccr_pkg.sv ====
// Shared constants, enums and carrier structs of the configuration cycle router.
// Assumes a single 100 MHz clock domain shared by host, hub link and graphics port logic.
package ccr_pkg;

  // Processor I/O decode
  localparam logic [15:0] CCR_PTR_ADDR = 16'h0cf8;
  localparam logic [15:0] CCR_DATA_ADDR = 16'h0cfc;
  localparam logic [3:0] CCR_BE_DWORD = 4'hf;

  // Target pointer layout
  localparam int CCR_EN_BIT = 31;
  localparam int CCR_BUS_LSB = 16;
  localparam int CCR_DEV_LSB = 11;
  localparam int CCR_FUNC_LSB = 8;
  localparam int CCR_REG_LSB = 2;
  localparam logic [31:0] CCR_PTR_RESET = 32'h0000_0000;
  localparam logic [31:0] CCR_PTR_WMASK = 32'h80ff_fffc;

  // Internal device numbers on logical bus 0
  localparam logic [4:0] CCR_DEV_HUB_BRIDGE = 5'h00;
  localparam logic [4:0] CCR_DEV_GFX_BRIDGE = 5'h01;
  localparam logic [4:0] CCR_DEV_STREAM = 5'h03;
  localparam logic [4:0] CCR_DEV_OVERFLOW = 5'h06;

  // Internal register store: dwords per device, bus number dword of graphics bridge
  localparam int CCR_INT_DEVS = 4;
  localparam int CCR_INT_DWORDS = 16;
  localparam logic [5:0] CCR_BUSNUM_DW = 6'h06;
  localparam logic [31:0] CCR_BUSNUM_WMASK = 32'h00ff_ff00;

  // Low address bits of outgoing configuration addresses
  localparam logic [1:0] CCR_A10_TYPE0 = 2'b00;
  localparam logic [1:0] CCR_A10_TYPE1 = 2'b01;

  typedef enum logic [2:0] {
    CCR_RT_NONE = 3'b000,
    CCR_RT_INT = 3'b001,
    CCR_RT_HUB0 = 3'b010,
    CCR_RT_HUB1 = 3'b011,
    CCR_RT_GP0 = 3'b100,
    CCR_RT_GP1 = 3'b101
  } ccr_route_e;

  typedef enum logic [1:0] {
    CCR_HK_IO = 2'b00,
    CCR_HK_CFG0 = 2'b01,
    CCR_HK_CFG1 = 2'b10
  } ccr_hub_kind_e;

  typedef struct packed {
    logic write;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ccr_io_req_s;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } ccr_link_s;

endpackage

// ==== hdl/ccr_route_decode.sv ====
// Combinational decode of the target pointer into a route and an outgoing address.
// Assumes secondary and subordinate bus numbers come from the internal register store.
module ccr_route_decode
  import ccr_pkg::*;
(
  input wire logic [31:0] ptr, // Target pointer contents
  input wire logic [7:0] sec_bus, // Graphics bridge secondary bus
  input wire logic [7:0] sub_bus, // Graphics bridge subordinate bus
  output ccr_route_e route, // Where the window access goes
  output logic [31:0] out_addr // Address for the outgoing cycle
);

  function automatic logic is_internal(input logic [4:0] dev);
    return (dev == CCR_DEV_HUB_BRIDGE) || (dev == CCR_DEV_GFX_BRIDGE) ||
           (dev == CCR_DEV_STREAM) || (dev == CCR_DEV_OVERFLOW);
  endfunction

  function automatic logic [15:0] idsel(input logic [4:0] dev);
    return dev[4] ? 16'h0000 : (16'h0001 << dev[3:0]);
  endfunction

  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] func;
  logic [5:0] dw;

  always_comb begin
    bus = ptr[CCR_BUS_LSB +: 8];
    dev = ptr[CCR_DEV_LSB +: 5];
    func = ptr[CCR_FUNC_LSB +: 3];
    dw = ptr[CCR_REG_LSB +: 6];
    route = CCR_RT_NONE;
    out_addr = {ptr[31:2], CCR_A10_TYPE0};
    if (!ptr[CCR_EN_BIT]) begin
      route = CCR_RT_NONE;
    end else if (bus == 8'h00) begin
      route = is_internal(dev) ? CCR_RT_INT : CCR_RT_HUB0;
    end else if (bus == sec_bus) begin
      route = CCR_RT_GP0;
      out_addr = {idsel(dev), 5'h00, func, dw, CCR_A10_TYPE0};
    end else if (bus > sec_bus && bus <= sub_bus) begin
      route = CCR_RT_GP1;
      out_addr = {8'h00, ptr[23:2], CCR_A10_TYPE1};
    end else begin
      route = CCR_RT_HUB1;
      out_addr = {ptr[31:2], CCR_A10_TYPE1};
    end
  end

endmodule

// ==== tb/ccr_config_cycle_router_tb.sv ====
// Self-checking bench of the configuration cycle router: I/O driver plus answer monitor.
// Assumes the link responder model stands on the hub link and graphics port side.
module ccr_config_cycle_router_tb import ccr_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, rst_n, io_req, io_busy, io_done, hub_req, gp_req, gp_type1;
  logic hub_done, gp_done, prev_req;
  logic [31:0] io_rdata, hub_rdata, gp_rdata, target_ptr, lfsr, p, w;
  logic [3:0] resp_delay;
  logic [40:0] link_got;
  ccr_io_req_s io_cmd;
  ccr_hub_kind_e hub_kind;
  ccr_link_s link_out;
  logic [32:0] exp_q[$];
  logic [40:0] link_q[$];
  logic [31:0] wd_q[$];
  logic [4:0] devs [4] = '{5'h00, 5'h01, 5'h03, 5'h06};
  logic [7:0] hub_bus [3] = '{8'h01, 8'h05, 8'hff};
  int num_errors, checked, i;

  ccr_config_cycle_router u_ccr_config_cycle_router (.sys_clk(sys_clk), .rst_n(rst_n),
    .io_req(io_req), .io_cmd(io_cmd), .io_busy(io_busy), .io_done(io_done),
    .io_rdata(io_rdata), .hub_req(hub_req), .hub_kind(hub_kind), .gp_req(gp_req),
    .gp_type1(gp_type1), .link_out(link_out), .hub_done(hub_done), .hub_rdata(hub_rdata),
    .gp_done(gp_done), .gp_rdata(gp_rdata), .target_ptr(target_ptr));

  ccr_link_responder u_ccr_link_responder (.sys_clk(sys_clk), .rst_n(rst_n),
    .hub_req(hub_req), .gp_req(gp_req), .link_out(link_out), .delay(resp_delay),
    .hub_done(hub_done), .gp_done(gp_done), .hub_rdata(hub_rdata), .gp_rdata(gp_rdata));

  assign link_got = {gp_req, gp_req & gp_type1, gp_req ? 2'b00 : 2'(hub_kind),
                     link_out.write, link_out.be, link_out.addr};

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [40:0] exp, input logic [40:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (exp_q.size() != 0) chk("answer wait", 41'h0, 41'h1);
  endtask

  // One processor I/O access; exp holds a check flag and the expected read data
  task automatic io(input logic wr, input logic [15:0] a, input logic [3:0] be,
                    input logic [31:0] wd, input logic [32:0] exp);
    exp_q.push_back(exp);
    @(negedge sys_clk);
    io_req = 1'b1;
    io_cmd = '{write: wr, addr: a, be: be, wdata: wd};
    @(negedge sys_clk);
    io_req = 1'b0;
    drain();
  endtask

  task automatic set_ptr(input logic [31:0] v);
    io(1'b1, CCR_PTR_ADDR, CCR_BE_DWORD, v, 33'h0);
  endtask

  // Access that must leave as an external cycle; m is {graphics, type1, hub kind}
  task automatic ext(input logic [3:0] m, input logic wr, input logic [3:0] be,
                     input logic [31:0] a, input logic [15:0] ioa);
    lfsr = lfsr_next(lfsr);
    resp_delay = {2'b00, lfsr[1:0]};
    link_q.push_back({m, wr, be, a});
    wd_q.push_back(lfsr);
    io(wr, ioa, be, lfsr, wr ? 33'h0 : {1'b1, ~a});
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    prev_req <= hub_req | gp_req;
    if (rst_n === 1'b1 && io_done === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected answer", 41'h0, 41'h1);
      end else begin
        if (exp_q[0][32]) chk("io_rdata", {9'h0, exp_q[0][31:0]}, {9'h0, io_rdata});
        void'(exp_q.pop_front());
      end
    end
    if (rst_n === 1'b1 && (hub_req | gp_req) === 1'b1 && prev_req !== 1'b1) begin
      if (link_q.size() == 0) begin
        chk("unexpected cycle", 41'h0, 41'h1);
      end else begin
        chk("link cycle", link_q[0], link_got);
        void'(link_q.pop_front());
        chk("link wdata", {9'h0, wd_q[0]}, {9'h0, link_out.wdata});
        void'(wd_q.pop_front());
      end
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #100000;
    chk("timeout", 41'h0, 41'h1);
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    io_req = 1'b0;
    io_cmd = '0;
    resp_delay = 4'h0;
    lfsr = 32'hb9db;
    num_errors = 0;
    checked = 0;
    repeat (3) @(negedge sys_clk);
    chk("reset pointer", 41'h0, {9'h0, target_ptr});
    rst_n = 1'b1;
    lfsr = lfsr_next(lfsr);
    p = lfsr;
    set_ptr(p);
    chk("target_ptr", {9'h0, p & CCR_PTR_WMASK}, {9'h0, target_ptr});
    io(1'b0, CCR_PTR_ADDR, CCR_BE_DWORD, 32'h0, {1'b1, p & CCR_PTR_WMASK});
    ext(4'h0, 1'b1, 4'h3, {16'h0, CCR_PTR_ADDR}, CCR_PTR_ADDR);
    chk("pointer kept", {9'h0, p & CCR_PTR_WMASK}, {9'h0, target_ptr});
    set_ptr(32'h0000_0800);
    ext(4'h0, 1'b0, 4'hf, {16'h0, CCR_DATA_ADDR}, CCR_DATA_ADDR);
    for (i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      set_ptr({8'h80, 8'h00, devs[i], 3'h0, 8'h3c});
      io(1'b1, CCR_DATA_ADDR, CCR_BE_DWORD, lfsr, 33'h0);
      io(1'b0, CCR_DATA_ADDR, CCR_BE_DWORD, 32'h0, {1'b1, lfsr});
    end
    set_ptr(32'h8000_0818);
    io(1'b1, CCR_DATA_ADDR, CCR_BE_DWORD, 32'hff04_0255, 33'h0);
    io(1'b0, CCR_DATA_ADDR, CCR_BE_DWORD, 32'h0, {1'b1, 32'h0004_0200});
    set_ptr(32'h8000_1010);
    ext(4'h1, 1'b0, 4'hf, 32'h8000_1010, CCR_DATA_ADDR);
    for (i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      p = {8'h80, hub_bus[i], lfsr[15:2], 2'b00};
      set_ptr(p);
      ext(4'h2, lfsr[16], lfsr[20:17] | 4'h1, {p[31:2], 2'b01}, CCR_DATA_ADDR);
    end
    for (i = 0; i < 32; i++) begin
      lfsr = lfsr_next(lfsr);
      p = {8'h80, 8'h02, i[4:0], lfsr[10:2], 2'b00};
      w = {(i < 16) ? 16'h0001 << i[3:0] : 16'h0000, 5'h00, p[10:2], 2'b00};
      set_ptr(p);
      ext(4'h8, 1'b0, 4'hf, w, CCR_DATA_ADDR);
    end
    for (i = 3; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      p = {8'h80, i[7:0], lfsr[15:2], 2'b00};
      set_ptr(p);
      ext(4'hc, 1'b0, 4'hf, {8'h00, p[23:2], 2'b01}, CCR_DATA_ADDR);
    end
    // A pointer write offered while a hub cycle is outstanding must be dropped
    set_ptr(32'h8001_0000);
    resp_delay = 4'h6;
    link_q.push_back({4'h2, 1'b0, 4'hf, 32'h8001_0001});
    wd_q.push_back(32'h0);
    exp_q.push_back({1'b1, ~32'h8001_0001});
    @(negedge sys_clk);
    io_req = 1'b1;
    io_cmd = '{write: 1'b0, addr: CCR_DATA_ADDR, be: CCR_BE_DWORD, wdata: 32'h0};
    @(negedge sys_clk);
    chk("io_busy", 41'h1, {40'h0, io_busy});
    io_cmd = '{write: 1'b1, addr: CCR_PTR_ADDR, be: CCR_BE_DWORD, wdata: 32'h0};
    @(negedge sys_clk);
    io_req = 1'b0;
    drain();
    chk("pointer held", {9'h0, 32'h8001_0000}, {9'h0, target_ptr});
    chk("link cycles left", 41'h0, 41'(link_q.size()));
    wrap_up();
  end
endmodule

// ==== tb/ccr_link_responder.sv ====
// Far-side model of the hub link and graphics port: answers each held request after a delay.
// Assumes one outstanding request at a time, held by the router until done is sampled.
module ccr_link_responder
  import ccr_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic hub_req, // Hub link request
  input wire logic gp_req, // Graphics port request
  input wire ccr_link_s link_out, // Cycle contents
  input wire logic [3:0] delay, // Wait cycles before done
  output logic hub_done, // Hub completion pulse
  output logic gp_done, // Graphics completion pulse
  output logic [31:0] hub_rdata, // Hub read data
  output logic [31:0] gp_rdata // Graphics read data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;
  logic [31:0] rdata;
  logic pend;

  assign pend = (hub_req | gp_req) & ~(hub_done | gp_done);
  assign hub_rdata = rdata;
  assign gp_rdata = rdata;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      hub_done <= 1'b0;
      gp_done <= 1'b0;
      rdata <= 32'h0;
    end else if (pend && cnt == delay) begin
      hub_done <= hub_req;
      gp_done <= gp_req;
      rdata <= ~link_out.addr;
      cnt <= 4'h0;
    end else begin
      hub_done <= 1'b0;
      gp_done <= 1'b0;
      // Data is only valid with done, so it keeps changing otherwise
      rdata <= ~rdata;
      cnt <= pend ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule
